// >>> ide_bridge_defs.svh
`ifndef IDE_BRIDGE_DEFS_SVH
`define IDE_BRIDGE_DEFS_SVH

// ************************************************************
// address map of the drive port, host i/o space
// ************************************************************
`define IDE_PRI_BASE 10'h1f0
`define IDE_PRI_LAST 10'h1f7
`define IDE_AUX_BASE 10'h3f6
`define IDE_AUX_LAST 10'h3f7
`define IDE_CHG_ADDR 10'h3f7
`define IDE_DATA_ADDR 10'h1f0

// ************************************************************
// reset values of the registered outputs
// ************************************************************
`define IDE_SEL_RST 1'h0
`define IDE_EN_N_RST 1'h1

`endif

// >>> ide_bridge_pkg.sv
package ide_bridge_pkg;

   typedef enum logic [2:0] {
      ACC_IDLE = 3'h1,
      ACC_READ = 3'h2,
      ACC_WRITE = 3'h4
   } access_t;

endpackage

// >>> select_decoder.sv
`timescale 1ns/1ns
`include "ide_bridge_defs.svh"

module select_decoder (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [9:0] host_addr,
   input wire logic decode_output_enable,
   input wire logic dma_ack_decode_inhibit,
   output logic pri_hit,
   output logic aux_hit,
   output logic chg_hit,
   output logic data_hit
);

   logic inh;

   // inhibit and a low output enable both mask every hit result alike
   assign inh = dma_ack_decode_inhibit | ~decode_output_enable;

   always_comb begin
      pri_hit = 1'b0;
      aux_hit = 1'b0;
      chg_hit = 1'b0;
      data_hit = 1'b0;
      if (!inh) begin
         pri_hit = (host_addr >= `IDE_PRI_BASE) &&
                   (host_addr <= `IDE_PRI_LAST);
         aux_hit = (host_addr >= `IDE_AUX_BASE) &&
                   (host_addr <= `IDE_AUX_LAST);
         chg_hit = (host_addr == `IDE_CHG_ADDR);
         data_hit = (host_addr == `IDE_DATA_ADDR);
      end
   end

   no_sel_inh_a: assert property (@(posedge mclk) disable iff (reset)
      dma_ack_decode_inhibit |-> !(pri_hit || aux_hit))
      else $error("select decoded while inhibited");

endmodule // select_decoder

// >>> ide_port_select_steering.sv
`timescale 1ns/1ns
`include "ide_bridge_defs.svh"
// Overview of operation
// - high-byte enable low only for 16-bit data transfers with primary select
// - low-byte enable low whenever either card select is asserted
// - on decoded write, drive bit 7 pin with host data bit 7
// - on decoded read, pass drive bit 7 onto host data bit 7
// - read of 3f7 returns disk-changed status on host bit 7
// - auxiliary select asserted for aux decode, low enable with it
// - primary select for channel registers, low enable, high for 16-bit data at 1f0
// - selects only with output enable; decode ignored while inhibited

module ide_port_select_steering (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [9:0] host_addr,
   input wire logic io_read_n,
   input wire logic io_write_n,
   input wire logic xfer_16bit,
   input wire logic decode_output_enable,
   input wire logic dma_ack_decode_inhibit,
   input wire logic disk_changed_n,
   input wire logic host_data_bit7_in,
   output logic host_data_bit7_out,
   output logic host_data_bit7_oe_n,
   input wire logic ide_data_bit7_in,
   output logic ide_data_bit7_out,
   output logic ide_data_bit7_oe_n,
   output logic ide_primary_select,
   output logic ide_aux_select,
   output logic ide_xcvr_enable_low_n,
   output logic ide_xcvr_enable_high_n
);

   // ************************************************************
   // address decode
   // ************************************************************
   logic pri_hit;
   logic aux_hit;
   logic chg_hit;
   logic data_hit;
   ide_bridge_pkg::access_t acc_d;
   ide_bridge_pkg::access_t acc_q;

   select_decoder u_dec (
      .mclk(mclk),
      .reset(reset),
      .host_addr(host_addr),
      .decode_output_enable(decode_output_enable),
      .dma_ack_decode_inhibit(dma_ack_decode_inhibit),
      .pri_hit(pri_hit),
      .aux_hit(aux_hit),
      .chg_hit(chg_hit),
      .data_hit(data_hit)
   );

   // ************************************************************
   // access state
   // ************************************************************
   logic any_hit;
   assign any_hit = pri_hit | aux_hit;

   always_comb begin
      case ({io_read_n, io_write_n})
         2'b01: acc_d = any_hit ? ide_bridge_pkg::ACC_READ :
                                  ide_bridge_pkg::ACC_IDLE;
         2'b10: acc_d = any_hit ? ide_bridge_pkg::ACC_WRITE :
                                  ide_bridge_pkg::ACC_IDLE;
         default: acc_d = ide_bridge_pkg::ACC_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         acc_q <= ide_bridge_pkg::ACC_IDLE;
      end else begin
         acc_q <= acc_d;
      end
   end

   // ************************************************************
   // card selects and transceiver enables, one cycle after decode
   // ************************************************************
   logic sel_strobe;
   assign sel_strobe = ~io_read_n | ~io_write_n;

   always_ff @(posedge mclk) begin
      if (reset) begin
         ide_primary_select <= `IDE_SEL_RST;
         ide_aux_select <= `IDE_SEL_RST;
         ide_xcvr_enable_low_n <= `IDE_EN_N_RST;
         ide_xcvr_enable_high_n <= `IDE_EN_N_RST;
      end else begin
         ide_primary_select <= pri_hit & sel_strobe;
         ide_aux_select <= aux_hit & sel_strobe;
         ide_xcvr_enable_low_n <= ~(any_hit & sel_strobe);
         // high byte only on a 16-bit data-port access
         ide_xcvr_enable_high_n <=
            ~(data_hit & xfer_16bit & sel_strobe);
      end
   end

   // ************************************************************
   // bit 7 steering
   // ************************************************************
   logic chg_rd_q;

   always_ff @(posedge mclk) begin
      if (reset) begin
         chg_rd_q <= 1'b0;
      end else begin
         chg_rd_q <= chg_hit & ~io_read_n;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ide_data_bit7_out <= 1'b0;
      end else if (acc_d == ide_bridge_pkg::ACC_WRITE) begin
         ide_data_bit7_out <= host_data_bit7_in;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         host_data_bit7_out <= 1'b0;
      end else if (acc_d == ide_bridge_pkg::ACC_READ) begin
         // status line sensed at the pin level, low means changed
         host_data_bit7_out <= (chg_hit ? disk_changed_n
                                        : ide_data_bit7_in);
      end
   end

   // never drive the drive's bit 7 outside a write, avoiding contention
   always_comb begin
      ide_data_bit7_oe_n = 1'b1;
      host_data_bit7_oe_n = 1'b1;
      case (acc_q)
         ide_bridge_pkg::ACC_WRITE: ide_data_bit7_oe_n = 1'b0;
         ide_bridge_pkg::ACC_READ: host_data_bit7_oe_n = 1'b0;
         ide_bridge_pkg::ACC_IDLE: ide_data_bit7_oe_n = 1'b1;
         default: ide_data_bit7_oe_n = 1'b1;
      endcase
   end

   // ************************************************************
   // checks
   // ************************************************************
   // reset stays in the request terms: a request sampled on the release
   // edge meets outputs that were still held in reset at that edge
   hi_needs_pri_a: assert property (@(posedge mclk) disable iff (reset)
      !ide_xcvr_enable_high_n |-> ide_primary_select)
      else $error("high enable without primary select");

   hi_en_16_a: assert property (@(posedge mclk) disable iff (reset)
      !ide_xcvr_enable_high_n |-> $past(xfer_16bit))
      else $error("high enable on an 8-bit access");

   hi_en_set_a: assert property (@(posedge mclk) disable iff (reset)
      (!reset && data_hit && xfer_16bit && sel_strobe) |=>
      !ide_xcvr_enable_high_n)
      else $error("high enable missing on 16-bit data access");

   low_with_sel_a: assert property (@(posedge mclk) disable iff (reset)
      (ide_primary_select || ide_aux_select) == !ide_xcvr_enable_low_n)
      else $error("low enable not tied to selects");

   low_en_set_a: assert property (@(posedge mclk) disable iff (reset)
      (!reset && any_hit && sel_strobe) |=> !ide_xcvr_enable_low_n)
      else $error("low enable missing on decoded access");

   wr_drive_a: assert property (@(posedge mclk) disable iff (reset)
      (!reset && any_hit && !io_write_n && io_read_n) |=>
      (!ide_data_bit7_oe_n && ide_data_bit7_out == $past(host_data_bit7_in)))
      else $error("write bit 7 not driven");

   rd_pass_a: assert property (@(posedge mclk) disable iff (reset)
      (!reset && any_hit && !chg_hit && !io_read_n && io_write_n) |=>
      (host_data_bit7_out == $past(ide_data_bit7_in)))
      else $error("read bit 7 not passed");

   rd_dir_a: assert property (@(posedge mclk) disable iff (reset)
      (!reset && any_hit && !io_read_n && io_write_n) |=>
      (ide_data_bit7_oe_n && !host_data_bit7_oe_n))
      else $error("read bit 7 steered the wrong way");

   host_idle_a: assert property (@(posedge mclk) disable iff (reset)
      (acc_q != ide_bridge_pkg::ACC_READ) |-> host_data_bit7_oe_n)
      else $error("host bit 7 driven outside read");

   chg_rd_a: assert property (@(posedge mclk) disable iff (reset)
      (chg_rd_q && $past(io_write_n)) |->
      (host_data_bit7_out == $past(disk_changed_n)))
      else $error("3f7 read lacks disk change");

   chg_drive_a: assert property (@(posedge mclk) disable iff (reset)
      (chg_rd_q && $past(io_write_n)) |-> !host_data_bit7_oe_n)
      else $error("3f7 read not driven to host");

   aux_sel_a: assert property (@(posedge mclk) disable iff (reset)
      (!reset && aux_hit && sel_strobe) |=>
      (ide_aux_select && !ide_xcvr_enable_low_n))
      else $error("aux select missing");

   pri_sel_a: assert property (@(posedge mclk) disable iff (reset)
      (!reset && pri_hit && sel_strobe) |=> ide_primary_select)
      else $error("primary select missing");

   sel_gated_a: assert property (@(posedge mclk) disable iff (reset)
      !decode_output_enable |=> !(ide_primary_select || ide_aux_select))
      else $error("select without output enable");

   sel_enabled_a: assert property (@(posedge mclk) disable iff (reset)
      (ide_primary_select || ide_aux_select) |->
      ($past(decode_output_enable) && !$past(dma_ack_decode_inhibit)))
      else $error("select from an inhibited decode");

   pin_idle_a: assert property (@(posedge mclk) disable iff (reset)
      (acc_q != ide_bridge_pkg::ACC_WRITE) |-> ide_data_bit7_oe_n)
      else $error("bit 7 driven outside write");

   clash_idle_a: assert property (@(posedge mclk) disable iff (reset)
      (!reset && !io_read_n && !io_write_n) |=>
      (ide_data_bit7_oe_n && host_data_bit7_oe_n))
      else $error("bit 7 driven during a strobe clash");

endmodule // ide_port_select_steering

// >>> ide_drive_model.sv
`timescale 1ns/1ns
// ************************************************************
// drive side of bit 7 and the floppy status line
// ************************************************************
module ide_drive_model (
   input wire logic mclk,
   input wire logic reset,
   input wire logic blk_oe_n,
   input wire logic blk_out,
   output logic wire_level,
   output logic disk_changed_n
);
   logic pat_q;
   logic [4:0] cnt_q;
   always_ff @(posedge mclk) begin
      if (reset) begin
         pat_q <= 1'h0;
         cnt_q <= 5'h0;
      end else begin
         pat_q <= ~pat_q;
         cnt_q <= cnt_q + 5'h1;
      end
   end
   // released wire toggles, so a stale value can never pass
   assign wire_level = blk_oe_n ? pat_q : blk_out;
   // active low, low while the door has been opened
   assign disk_changed_n = ~(cnt_q[4] & cnt_q[2]);
endmodule // ide_drive_model

// >>> tb_top.sv
`timescale 1ns/1ns
// ************************************************************
// random traffic against a reference model, one cycle behind
// ************************************************************
module tb_top;
   logic mclk, reset, rd_n, wr_n, x16, oe_in, inh;
   logic [9:0] addr, s_addr;
   logic hd_in, hd_out, hd_oe_n, id_lvl, id_out, id_oe_n;
   logic pri, aux, en_l_n, en_h_n, chg_n;
   logic s_rst, s_rd_n, s_wr_n, s_16, s_ok, s_hd, s_id, s_dc;
   logic rd, wr, st, hp, ha, dp, ds;
   logic [17:0] snap_q[$];
   integer seed, fails, n_checks, i, r;
   ide_port_select_steering ide_port_select_steering_inst (
      .mclk(mclk), .reset(reset), .host_addr(addr), .io_read_n(rd_n),
      .io_write_n(wr_n), .xfer_16bit(x16), .decode_output_enable(oe_in),
      .dma_ack_decode_inhibit(inh), .disk_changed_n(chg_n),
      .host_data_bit7_in(hd_in), .host_data_bit7_out(hd_out),
      .host_data_bit7_oe_n(hd_oe_n), .ide_data_bit7_in(id_lvl),
      .ide_data_bit7_out(id_out), .ide_data_bit7_oe_n(id_oe_n),
      .ide_primary_select(pri), .ide_aux_select(aux),
      .ide_xcvr_enable_low_n(en_l_n), .ide_xcvr_enable_high_n(en_h_n));
   ide_drive_model ide_drive_model_inst (.mclk(mclk), .reset(reset),
      .blk_oe_n(id_oe_n), .blk_out(id_out), .wire_level(id_lvl),
      .disk_changed_n(chg_n));
   task check(input string name, input logic exp, input logic seen);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task results;
      if (fails == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // what the design samples at each edge, queued for the reference model
   always @(posedge mclk) begin
      snap_q.push_back({reset, oe_in & ~inh, rd_n, wr_n, x16, hd_in, id_lvl,
         chg_n, addr});
   end
   // reference model, compared once the outputs of that edge have settled
   always @(negedge mclk) begin
      if (snap_q.size() > 0) begin
         {s_rst, s_ok, s_rd_n, s_wr_n, s_16, s_hd, s_id, s_dc, s_addr} =
            snap_q.pop_front();
         rd = ~s_rd_n & s_wr_n;
         wr = s_rd_n & ~s_wr_n;
         // selects follow either strobe, a clash of both included
         st = ~s_rd_n | ~s_wr_n;
         hp = ~s_rst & s_ok & (s_addr >= 10'h1f0) & (s_addr <= 10'h1f7);
         ha = ~s_rst & s_ok & (s_addr >= 10'h3f6) & (s_addr <= 10'h3f7);
         dp = hp & (s_addr == 10'h1f0);
         ds = (s_addr == 10'h3f7);
         if (s_rst || !s_ok) begin
            check("pri_sel", 1'h0, pri);
            check("aux_sel", 1'h0, aux);
         end else begin
            check("pri_sel", hp & st, pri);
            check("aux_sel", ha & st, aux);
         end
         check("en_low_n", ~((hp | ha) & st), en_l_n);
         check("en_high_n", ~(dp & st & s_16), en_h_n);
         check("ide_oe_n", ~(wr & (hp | ha)), id_oe_n);
         if (wr && (hp || ha)) check("ide_out", s_hd, id_out);
         check("host_oe_n", ~(rd & (hp | ha)), hd_oe_n);
         if (rd && (hp || ha))
            check("host_out", ds ? s_dc : s_id, hd_out);
      end
   end
   // traffic takes about 3,000 cycles; a hang is caught at 40,000, over thirteen times that
   initial begin
      #400000;
      fails = fails + 1;
      results;
   end
   initial begin
      seed = 32'h4b12;
      fails = 0;
      n_checks = 0;
      reset = 1'h1;
      rd_n = 1'h1;
      wr_n = 1'h1;
      x16 = 1'h0;
      oe_in = 1'h1;
      inh = 1'h0;
      addr = 10'h0;
      hd_in = 1'h0;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      // mid-run reset and every mix of strobes, clashes, ranges and gating
      for (i = 0; i < 3000; i = i + 1) begin
         @(posedge mclk);
         reset <= (i >= 1500 && i < 1503);
         r = $random(seed);
         oe_in <= (r[2:0] != 3'h0);
         inh <= (r[5:3] == 3'h0);
         rd_n <= ~r[6] | (r[8] & r[9]);
         wr_n <= ~r[7] | (r[8] & r[9]);
         x16 <= r[10];
         hd_in <= r[11];
         case (r[13:12])
            2'h0: addr <= 10'h1f0 + {7'h0, r[16:14]};
            2'h1: addr <= 10'h3f6 + {9'h0, r[14]};
            2'h2: addr <= 10'h1f0;
            default: addr <= r[25:16];
         endcase
      end
      results;
   end
endmodule // tb_top
